// File: sim/rsw_pin_model.sv
// Purpose: External reset source driving the reset pin.
// Assumes: Pin has a pull-up, so it idles high.
// Notes:   A start pulse loads the low time in clocks.
`timescale 1ns/1ps

module rsw_pin_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [8:0] len_i,
  output logic            pin_b_o
);
  logic [8:0] cnt_r = 9'h000;

  // Pulled high whenever the source is idle
  assign pin_b_o = (cnt_r == 9'h000);
  always @(posedge clk_i)
    if (go_i)
      cnt_r <= len_i;
    else if (cnt_r != 9'h000)
      cnt_r <= cnt_r - 9'h001;
endmodule : rsw_pin_model

// File: sim/rsw_top_assertions.sv
// Purpose: Port-level checks for the reset and watchdog block.
// Assumes: Start-up select fuses at zero.
// Notes:   Bound into rsw_top.
`timescale 1ns/1ps
`include "rsw_params.svh"

module rsw_top_assertions (
  input wire logic                   clk_i,
  input wire logic                   rst_b_i,
  input wire logic                   reset_pin_b_i,
  input wire logic                   jtag_reset_instruction_i,
  input wire logic                   brownout_enable_fuse_i,
  input wire logic                   comparator_bandgap_select_i,
  input wire logic                   adc_enable_i,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`RSW_ADDR_W-1:0] paddr,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   core_reset_b_o,
  input wire logic                   bandgap_on_o
);
  // ****
  // Helper: consecutive pin-low cycles, saturating
  // ****
  logic [8:0] pin_low_r;
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
      pin_low_r <= 9'h000;
    else if (reset_pin_b_i)
      pin_low_r <= 9'h000;
    else if (pin_low_r != 9'h1FF)
      pin_low_r <= pin_low_r + 9'h001;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_start_hold: assert property ($rose(rst_b_i) |-> !core_reset_b_o [*3])
    else $error("core reset released too early");
  a_pin_reset: assert property (pin_low_r == 9'h0C8 |-> !core_reset_b_o)
    else $error("long pin pulse did not reset");
  a_release_delay: assert property ($rose(core_reset_b_o) |->
    $past(reset_pin_b_i, 4) && !$past(jtag_reset_instruction_i, 4))
    else $error("release without start-up delay");
  a_jtag_hold: assert property (jtag_reset_instruction_i [*5] |-> !core_reset_b_o)
    else $error("jtag request did not reset");
  a_bgap_on: assert property ((comparator_bandgap_select_i || adc_enable_i) |=> bandgap_on_o)
    else $error("bandgap not on");
  a_bgap_off: assert property (!(brownout_enable_fuse_i || comparator_bandgap_select_i
    || adc_enable_i) [*4] |-> !bandgap_on_o)
    else $error("bandgap not off");
  a_rsvd_zero: assert property (pready && !pwrite && paddr == `RSW_OFS_WDCTRL
    |-> prdata[31:5] == 27'h0)
    else $error("reserved bits not zero");
  a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready timing wrong");
  a_unmapped_err: assert property (psel && penable && pready |->
    (pslverr == (paddr > `RSW_OFS_STATUS)))
    else $error("error response wrong");
endmodule : rsw_top_assertions

bind rsw_top rsw_top_assertions u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .reset_pin_b_i(reset_pin_b_i), .jtag_reset_instruction_i(jtag_reset_instruction_i),
  .brownout_enable_fuse_i(brownout_enable_fuse_i), .adc_enable_i(adc_enable_i),
  .comparator_bandgap_select_i(comparator_bandgap_select_i), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .core_reset_b_o(core_reset_b_o), .bandgap_on_o(bandgap_on_o));

// File: sim/tb.sv
// Purpose: Self-checking bench for the reset and watchdog block.
// Assumes: Start-up unit of 4 clocks, select fuses at zero.
// Notes:   Watchdog oscillator runs at a quarter of the clock.
`timescale 1ns/1ps
`include "rsw_params.svh"

module tb;
  import rsw_pkg::*;
  logic        clk_i = 0, rst_b_i = 0, bod_en = 0, bod_lvl = 0, comparator_bandgap_select = 0, adc = 0;
  logic        kick = 0, go = 0, psel = 0, penable = 0, pwrite = 0;
  logic [2:0]  src = 3'h0;
  logic [1:0]  od = 2'h0;
  logic [8:0]  len = 9'h000;
  logic [`RSW_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, core_b, bg, pin_b, err;
  int          miscompares = 0, n_tests = 0, cyc = 0, lows = 0, d, t0;

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    od <= od + 2'h1;
    lows <= lows + int'(!core_b);
    cyc <= cyc + 1;
    if (cyc == 100000)
    begin
      miscompares++;
      summarize();
    end
  end

  rsw_pin_model u_pin (.clk_i(clk_i), .go_i(go), .len_i(len), .pin_b_o(pin_b));
  rsw_top #(.STARTUP_UNIT_CYC(4)) DUT (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .reset_pin_b_i(pin_b), .bod_below_low_i(src[0]), .bod_below_high_i(src[1]),
    .brownout_enable_fuse_i(bod_en), .brownout_trip_level_fuse_i(bod_lvl),
    .jtag_reset_instruction_i(src[2]), .wdt_osc_i(od[1]), .startup_delay_select_i(3'h0),
    .comparator_bandgap_select_i(comparator_bandgap_select), .adc_enable_i(adc), .wdt_kick_i(kick),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_reset_b_o(core_b),
    .bandgap_on_o(bg));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [`RSW_ADDR_W-1:0] a, input logic [31:0] v);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk_i);
    penable <= 1'b1;
    // Ready is registered: look at it mid-cycle, before the edge that samples it
    @(negedge clk_i);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(negedge clk_i);
    end
    chk(n < 20, 1'b1);
    rd = prdata;
    err = pslverr;
    @(posedge clk_i);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  task automatic wr(input logic [`RSW_ADDR_W-1:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask : wr

  task automatic rd_chk(input logic [`RSW_ADDR_W-1:0] a, input logic [31:0] v);
    apb(1'b0, a, 32'h0);
    chk(rd, v);
  endtask : rd_chk

  // Holds the comparator/jtag lines or fires the pin model, returns reset cycles
  task automatic stim(input logic [2:0] v, input logic p, input int n, output int dl);
    int l0;
    l0 = lows;
    src <= v;
    go <= p;
    len <= n[8:0];
    @(posedge clk_i);
    go <= 1'b0;
    repeat (n) @(posedge clk_i);
    src <= 3'h0;
    repeat (20) @(posedge clk_i);
    dl = lows - l0;
    chk(core_b, 1'b1);
  endtask : stim

  task automatic t_por();
    repeat (20) @(posedge clk_i);
    chk(core_b, 1'b1);
    rd_chk(`RSW_OFS_FLAGS, 32'h01);
    wr(`RSW_OFS_FLAGS, 32'h0);
    rd_chk(`RSW_OFS_FLAGS, 32'h0);
    rd_chk(12'h00C, 32'h0);
    chk(err, 1'b1);
  endtask : t_por

  task automatic t_pin();
    stim(3'h0, 1'b1, 100, d);
    chk(d, 0);
    stim(3'h0, 1'b1, 250, d);
    chk(d != 0, 1'b1);
    rd_chk(`RSW_OFS_FLAGS, 32'h02);
    wr(`RSW_OFS_FLAGS, 32'h0);
  endtask : t_pin

  task automatic t_bod();
    bod_en <= 1'b1;
    stim(3'h2, 1'b0, 300, d);
    chk(d, 0);
    stim(3'h1, 1'b0, 100, d);
    chk(d, 0);
    stim(3'h1, 1'b0, 300, d);
    chk(d != 0, 1'b1);
    chk(bg, 1'b1);
    rd_chk(`RSW_OFS_FLAGS, 32'h04);
    wr(`RSW_OFS_FLAGS, 32'h0);
    bod_lvl <= 1'b1;
    stim(3'h2, 1'b0, 300, d);
    chk(d != 0, 1'b1);
    bod_en <= 1'b0;
    wr(`RSW_OFS_FLAGS, 32'h0);
  endtask : t_bod

  task automatic t_jtag();
    stim(3'h4, 1'b0, 20, d);
    chk(d != 0, 1'b1);
    rd_chk(`RSW_OFS_FLAGS, 32'h10);
    rst_b_i <= 1'b0;
    @(posedge clk_i);
    #1 chk(core_b, 1'b0);
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rd_chk(`RSW_OFS_FLAGS, 32'h01);
    wr(`RSW_OFS_FLAGS, 32'h0);
  endtask : t_jtag

  task automatic t_bgap();
    comparator_bandgap_select <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(bg, 1'b1);
    comparator_bandgap_select <= 1'b0;
    adc <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(bg, 1'b1);
    adc <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(bg, 1'b0);
  endtask : t_bgap

  task automatic t_wd();
    wr(`RSW_OFS_WDCTRL, 32'h08);
    wr(`RSW_OFS_WDCTRL, 32'h00);
    rd_chk(`RSW_OFS_WDCTRL, 32'h08);
    wr(`RSW_OFS_WDCTRL, 32'hEF);
    rd_chk(`RSW_OFS_WDCTRL, 32'h0F);
    wr(`RSW_OFS_WDCTRL, 32'h18);
    wr(`RSW_OFS_WDCTRL, 32'h00);
    rd_chk(`RSW_OFS_WDCTRL, 32'h00);
    wr(`RSW_OFS_WDCTRL, 32'h18);
    repeat (6) @(posedge clk_i);
    wr(`RSW_OFS_WDCTRL, 32'h00);
    rd_chk(`RSW_OFS_WDCTRL, 32'h08);
    repeat (100) @(posedge clk_i);
    kick <= 1'b1;
    @(posedge clk_i);
    kick <= 1'b0;
    t0 = cyc;
    while (core_b === 1'b1 && cyc - t0 < 70000) @(posedge clk_i);
    // Period code 000 at four clocks per oscillator cycle
    d = cyc - t0;
    chk(d >= (16384 * 4 - 8) && d <= (16384 * 4 + 16), 1'b1);
    repeat (20) @(posedge clk_i);
    chk(core_b, 1'b1);
    rd_chk(`RSW_OFS_FLAGS, 32'h08);
    rd_chk(`RSW_OFS_WDCTRL, 32'h00);
  endtask : t_wd

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_por();
    t_pin();
    t_bod();
    t_jtag();
    t_bgap();
    t_wd();
    summarize();
  end
endmodule : tb

// File: src/rsw_params.svh
// Purpose: Constants for the reset-source and watchdog block.
// Assumes: 125 MHz system clock, APB register access.
// Notes:   Offsets are byte addresses on the APB.
`ifndef RSW_PARAMS_SVH
`define RSW_PARAMS_SVH

// ************************************************************
// Register map
// ************************************************************
`define RSW_ADDR_W          12
`define RSW_OFS_FLAGS       12'h000
`define RSW_OFS_WDCTRL      12'h004
`define RSW_OFS_STATUS      12'h008

// ************************************************************
// Reset cause flag positions
// ************************************************************
`define RSW_FLAG_W          5
`define RSW_FLAG_POR        0
`define RSW_FLAG_PIN        1
`define RSW_FLAG_BOD        2
`define RSW_FLAG_WD         3
`define RSW_FLAG_JTAG       4
`define RSW_FLAGS_RST       5'h01

// ************************************************************
// Watchdog control fields
// ************************************************************
`define RSW_WD_TOE          4
`define RSW_WD_WDE          3
`define RSW_WD_WDP_HI       2
`define RSW_WD_WDP_LO       0
`define RSW_WD_CNT_W        21
`define RSW_WD_BASE_LOG2    5'h0E
`define RSW_TOE_CYC         3'h4

// ************************************************************
// Timing
// ************************************************************
`define RSW_CLK_MHZ         125
`define RSW_T_PIN_MIN_NS    1500
`define RSW_T_BOD_MIN_NS    2000
`define RSW_PIN_MIN_CYC     ((`RSW_T_PIN_MIN_NS * `RSW_CLK_MHZ + 999) / 1000)
`define RSW_BOD_MIN_CYC     ((`RSW_T_BOD_MIN_NS * `RSW_CLK_MHZ + 999) / 1000)
`define RSW_FILT_W          8
`define RSW_STARTUP_UNIT    512
`define RSW_DLY_W           32

// ************************************************************
// Input synchroniser lanes
// ************************************************************
`define RSW_SYNC_W          10
`define RSW_SY_PIN_B        0
`define RSW_SY_BOD_LO       1
`define RSW_SY_BOD_HI       2
`define RSW_SY_BOD_EN       3
`define RSW_SY_BOD_LVL      4
`define RSW_SY_JTAG         5
`define RSW_SY_OSC          6
`define RSW_SY_SEL_LO       7
`define RSW_SY_SEL_HI       9
`define RSW_SYNC_RST        10'h001

`endif

// File: src/rsw_pkg.sv
// Purpose: Types for the reset-source and watchdog block.
// Assumes: rsw_params.svh holds the field widths, except the 3-bit and 32-bit ones.
// Notes:   Whole block state is one packed struct.
`include "rsw_params.svh"

package rsw_pkg;

  typedef enum logic [2:0] {
    RSW_HOLD  = 3'b001,
    RSW_DELAY = 3'b010,
    RSW_RUN   = 3'b100
  } rsw_state_t;

  typedef struct packed {
    logic [`RSW_SYNC_W-1:0] sy1;
    logic [`RSW_SYNC_W-1:0] sy2;
    logic                   osc_prev;
    rsw_state_t             st;
    logic                   core_rst_b;
    logic [`RSW_DLY_W-1:0]  dly_cnt;
    logic [`RSW_FILT_W-1:0] pin_cnt;
    logic                   pin_act;
    logic [`RSW_FILT_W-1:0] bod_cnt;
    logic                   bod_act;
    logic [`RSW_WD_CNT_W-1:0] wd_cnt;
    logic                   wd_pulse;
    logic                   watchdog_enable;
    logic                   toe;
    logic [2:0]             toe_cnt;
    logic [2:0]             wdp;
    logic [`RSW_FLAG_W-1:0] flags;
    logic                   bandgap;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
  } rsw_regs_t;

endpackage : rsw_pkg

// File: src/rsw_top.sv
// Purpose: Reset sources, start-up delay, reset cause flags and watchdog.
// Assumes: rst_b_i is the power-on detector output (low = supply below level).
// Notes:   Analog comparators and the watchdog oscillator arrive as pins.
//
// What this block does
// - After power-on release, run start-up delay, hold core reset until it ends.
// - Supply below power-on level reasserts core reset at once, no delay.
// - Pin low longer than minimum width resets; shorter pulses may be ignored.
// - Pin back high starts delay; core leaves reset after time-out.
// - Trip-level fuse picks low level unprogrammed, high level programmed.
// - Enabled brownout resets immediately; release only after delay time-out.
// - Brownout ignored unless supply stays low longer than minimum period.
// - Watchdog time-out makes a one-cycle reset pulse; its end starts delay.
// - JTAG flag set by JTAG reset register; cleared by power-on or write zero.
// - Watchdog, brownout, pin flags set by their reset; cleared likewise.
// - Power-on flag set at power-on; only a software zero write clears it.
// - Bandgap on when brownout enabled, comparator bandgap select, or converter on.
// - Watchdog counts ticks of its own 1 MHz oscillator.
// - Watchdog counter cleared by kick, while disabled, and on chip reset.
// - Period elapsing without kick while enabled resets the chip.
// - Watchdog control bits 7 to 5 read zero.
// - Turn-off enable bit clears itself four clocks after being written one.
// - Enable written one enables; zero only acts while turn-off enable is one.
// - Disable: write both bits one, then enable zero within four clocks.
// - Period select: 16384 oscillator cycles for 000, doubling up to 111.
// - Start-up time-out length comes from the start-up delay select fuses.
// - Reset asserts immediately on any active source, without clock; here only power-on does, other sources are synchronised and clocked.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps

module rsw_top
  import rsw_pkg::*;
#(
  parameter int unsigned STARTUP_UNIT_CYC = `RSW_STARTUP_UNIT
)
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   reset_pin_b_i,
  input  wire logic                   bod_below_low_i,
  input  wire logic                   bod_below_high_i,
  input  wire logic                   brownout_enable_fuse_i,
  input  wire logic                   brownout_trip_level_fuse_i,
  input  wire logic                   jtag_reset_instruction_i,
  input  wire logic                   wdt_osc_i,
  input  wire logic [2:0]             startup_delay_select_i,
  input  wire logic                   comparator_bandgap_select_i,
  input  wire logic                   adc_enable_i,
  input  wire logic                   wdt_kick_i,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`RSW_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        core_reset_b_o,
  output logic                        bandgap_on_o
);

  rsw_regs_t q_r;
  rsw_regs_t q_nxt;

  // ************************************************************
  // Register reset image
  // ************************************************************
  localparam rsw_regs_t RSW_RST = '{
    sy1:        `RSW_SYNC_RST,
    sy2:        `RSW_SYNC_RST,
    osc_prev:   1'b0,
    st:         RSW_DELAY,
    core_rst_b: 1'b0,
    dly_cnt:    '0,
    pin_cnt:    '0,
    pin_act:    1'b0,
    bod_cnt:    '0,
    bod_act:    1'b0,
    wd_cnt:     '0,
    wd_pulse:   1'b0,
    watchdog_enable:        1'b0,
    toe:        1'b0,
    toe_cnt:    3'h0,
    wdp:        3'h0,
    flags:      `RSW_FLAGS_RST,
    bandgap:    1'b0,
    pready:     1'b0,
    pslverr:    1'b0,
    prdata:     32'h0000_0000
  };

  logic [`RSW_SYNC_W-1:0] raw_in;
  assign raw_in = {startup_delay_select_i, wdt_osc_i, jtag_reset_instruction_i,
                   brownout_trip_level_fuse_i, brownout_enable_fuse_i,
                   bod_below_high_i, bod_below_low_i, reset_pin_b_i};

  logic                   bod_below;
  logic                   osc_tick;
  logic                   wd_expire;
  logic                   any_src;
  logic [`RSW_DLY_W-1:0]  dly_last;
  logic [`RSW_WD_CNT_W-1:0] wd_last;
  logic                   acc;
  logic                   wr;
  logic [`RSW_ADDR_W-1:0] a;
  logic [31:0]            rd;
  logic                   hit;

  always_comb
  begin
    q_nxt = q_r;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    q_nxt.sy1 = raw_in;
    q_nxt.sy2 = q_r.sy1;
    q_nxt.osc_prev = q_r.sy2[`RSW_SY_OSC];
    osc_tick = q_r.sy2[`RSW_SY_OSC] & ~q_r.osc_prev;

    // ************************************************************
    // Pin and brownout filters
    // ************************************************************
    if (!q_r.sy2[`RSW_SY_PIN_B])
    begin
      if (q_r.pin_cnt != `RSW_FILT_W'(`RSW_PIN_MIN_CYC))
        q_nxt.pin_cnt = q_r.pin_cnt + `RSW_FILT_W'(1);
      else
        q_nxt.pin_act = 1'b1;
    end
    else
    begin
      q_nxt.pin_cnt = '0;
      q_nxt.pin_act = 1'b0;
    end

    bod_below = q_r.sy2[`RSW_SY_BOD_LVL] ? q_r.sy2[`RSW_SY_BOD_HI]
                                         : q_r.sy2[`RSW_SY_BOD_LO];
    if (q_r.sy2[`RSW_SY_BOD_EN] && bod_below)
    begin
      if (q_r.bod_cnt != `RSW_FILT_W'(`RSW_BOD_MIN_CYC))
        q_nxt.bod_cnt = q_r.bod_cnt + `RSW_FILT_W'(1);
      else
        q_nxt.bod_act = 1'b1;
    end
    else
    begin
      q_nxt.bod_cnt = '0;
      q_nxt.bod_act = 1'b0;
    end

    // ************************************************************
    // Watchdog counter
    // ************************************************************
    wd_last = `RSW_WD_CNT_W'((22'h1 << (`RSW_WD_BASE_LOG2 + {2'b00, q_r.wdp})) - 22'h1);
    wd_expire = q_r.watchdog_enable && osc_tick && (q_r.wd_cnt == wd_last);
    q_nxt.wd_pulse = wd_expire;
    if (!q_r.core_rst_b || !q_r.watchdog_enable || wdt_kick_i || wd_expire)
      q_nxt.wd_cnt = '0;
    else if (osc_tick)
      q_nxt.wd_cnt = q_r.wd_cnt + `RSW_WD_CNT_W'(1);

    // ************************************************************
    // Reset sequencing
    // ************************************************************
    any_src = q_r.pin_act | q_r.bod_act | q_r.wd_pulse | q_r.sy2[`RSW_SY_JTAG];
    dly_last = `RSW_DLY_W'(STARTUP_UNIT_CYC) << q_r.sy2[`RSW_SY_SEL_HI:`RSW_SY_SEL_LO];
    case (q_r.st)
      RSW_HOLD:
      begin
        q_nxt.dly_cnt = '0;
        if (!any_src)
          q_nxt.st = RSW_DELAY;
      end
      RSW_DELAY:
      begin
        if (any_src)
          q_nxt.st = RSW_HOLD;
        else if (q_r.dly_cnt == dly_last - `RSW_DLY_W'(1))
          q_nxt.st = RSW_RUN;
        else
          q_nxt.dly_cnt = q_r.dly_cnt + `RSW_DLY_W'(1);
      end
      RSW_RUN:
      begin
        q_nxt.dly_cnt = '0;
        if (any_src)
          q_nxt.st = RSW_HOLD;
      end
      default:
      begin
        q_nxt.st = RSW_HOLD;
      end
    endcase
    q_nxt.core_rst_b = (q_nxt.st == RSW_RUN);

    // ************************************************************
    // APB slave, no wait states
    // ************************************************************
    acc = psel & penable & q_r.pready;
    wr = acc & pwrite;
    a = paddr;
    hit = (a == `RSW_OFS_FLAGS) || (a == `RSW_OFS_WDCTRL) || (a == `RSW_OFS_STATUS);
    rd = 32'h0000_0000;
    case (a)
      `RSW_OFS_FLAGS:  rd[`RSW_FLAG_W-1:0] = q_r.flags;
      `RSW_OFS_WDCTRL: rd[7:0] = {3'b000, q_r.toe, q_r.watchdog_enable, q_r.wdp};
      `RSW_OFS_STATUS: rd[2:0] = {q_r.bandgap, q_r.core_rst_b, q_r.wd_pulse};
      default:         rd = 32'h0000_0000;
    endcase
    q_nxt.pready = psel & ~penable;
    if (psel && !penable)
    begin
      q_nxt.prdata = pwrite ? 32'h0000_0000 : rd;
      q_nxt.pslverr = ~hit;
    end

    // ************************************************************
    // Watchdog control register
    // ************************************************************
    if (q_r.toe)
    begin
      if (q_r.toe_cnt == 3'h1)
        q_nxt.toe = 1'b0;
      q_nxt.toe_cnt = q_r.toe_cnt - 3'h1;
    end
    if (wr && a == `RSW_OFS_WDCTRL)
    begin
      q_nxt.wdp = pwdata[`RSW_WD_WDP_HI:`RSW_WD_WDP_LO];
      // Zero only sticks inside the turn-off window
      q_nxt.watchdog_enable = pwdata[`RSW_WD_WDE] | (q_r.watchdog_enable & ~q_r.toe);
      if (pwdata[`RSW_WD_TOE])
      begin
        q_nxt.toe = 1'b1;
        q_nxt.toe_cnt = `RSW_TOE_CYC;
      end
    end
    if (!q_r.core_rst_b)
    begin
      q_nxt.watchdog_enable = 1'b0;
      q_nxt.toe = 1'b0;
      q_nxt.toe_cnt = 3'h0;
      q_nxt.wdp = 3'h0;
    end

    // ************************************************************
    // Reset cause flags, set wins over clear
    // ************************************************************
    if (wr && a == `RSW_OFS_FLAGS)
      q_nxt.flags = q_r.flags & pwdata[`RSW_FLAG_W-1:0];
    if (q_r.sy2[`RSW_SY_JTAG])
      q_nxt.flags[`RSW_FLAG_JTAG] = 1'b1;
    if (q_r.wd_pulse)
      q_nxt.flags[`RSW_FLAG_WD] = 1'b1;
    if (q_r.bod_act)
      q_nxt.flags[`RSW_FLAG_BOD] = 1'b1;
    if (q_r.pin_act)
      q_nxt.flags[`RSW_FLAG_PIN] = 1'b1;

    // ************************************************************
    // Bandgap enable
    // ************************************************************
    q_nxt.bandgap = q_r.sy2[`RSW_SY_BOD_EN] | comparator_bandgap_select_i
                    | adc_enable_i;
  end

  // Power-on sets the power-on flag, the pin synchroniser lanes and the DELAY state, and clears the rest
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      q_r <= RSW_RST;
    else
      q_r <= q_nxt;
  end

  assign prdata = q_r.prdata;
  assign pready = q_r.pready;
  assign pslverr = q_r.pslverr;
  assign core_reset_b_o = q_r.core_rst_b;
  assign bandgap_on_o = q_r.bandgap;

endmodule : rsw_top
